// ### dv/counter_host_image_interface_bench.sv
// testbench for the counter host image block
`timescale 1ns/1ps
module counter_host_image_interface_bench import hcimg_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] cin = 5'h00;
    logic [2:0] flt = 3'h0;
    logic lost = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, rdd, v;
    logic we, re, irq;
    logic [19:0] dout;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    hcimg_host u_host (.clk(clk), .addr(addr), .wr_data(wd), .wr_en(we), .rd_en(re), .rd_data(rdd));
    hcimg_top #(.PULSE_CYCLES(8)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wd), .wr_en(we),
        .rd_en(re), .rd_data(rdd), .count_in(cin), .short_fault(flt[0]), .undervolt_fault(flt[1]),
        .clock_fault(flt[2]), .host_link_lost(lost), .dout(dout), .irq(irq));
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        u_host.rd(a, v);
        chk(v, exp);
    endtask
    task automatic cnt(input int ch, input int n);
        repeat (n) begin
            @(posedge clk) cin[ch] <= 1'b1;
            @(posedge clk) cin[ch] <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic t_count_up;
        u_host.wr(8'h40, 6);
        u_host.wr(8'h60, 2);
        u_host.wr(8'h80, 4);
        u_host.wr(OFS_IRQ_MASK, 1);
        u_host.wr(8'h20, 8'h11);
        cnt(0, 3);
        rc(8'hA0, 3);
        rc(OFS_SP1, 1);
        rc(OFS_SP2, 0);
        chk(32'(irq), 0);
        cnt(0, 3);
        rc(OFS_TERM, 1);
        chk(32'(dout[2:0]), 7);
        chk(32'(irq), 1);
        rc(OFS_IRQ_STATUS, 1);
        u_host.wr(OFS_IRQ_STATUS, 1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 0);
    endtask
    task automatic t_modes;
        u_host.wr(8'h44, 2);
        u_host.wr(8'h24, 8'h19);
        repeat (2) @(posedge clk);
        rc(8'hA4, 2);
        cnt(1, 1);
        rc(8'hA4, 1);
        cnt(1, 2);
        rc(OFS_ERROR, 32'h02);
        u_host.wr(8'h48, 5);
        u_host.wr(8'h28, 8'h01);
        cnt(2, 2);
        rc(8'hA8, 0);
        u_host.wr(8'h4C, 10);
        u_host.wr(8'h2C, 8'h12);
        cnt(3, 2);
        rc(8'hAC, 2);
        u_host.wr(OFS_GLOBAL, 32'h12);
        u_host.wr(8'h50, 10);
        u_host.wr(8'h70, 4);
        u_host.wr(8'h90, 2);
        u_host.wr(8'h30, 8'h11);
        cnt(4, 7);
        u_host.rd(OFS_SP1, v);
        chk(32'(v[4]), 1);
        u_host.rd(OFS_SP2, v);
        chk(32'(v[4]), 0);
        cnt(4, 3);
        chk(32'(dout[19:16]), 15);
        repeat (10) @(posedge clk);
        chk(32'(dout[19:16]), 7);
    endtask
    task automatic t_faults;
        @(posedge clk) flt <= 3'h1;
        @(posedge clk) flt <= 3'h0;
        repeat (2) @(posedge clk);
        rc(OFS_ERROR, 32'h40);
        u_host.wr(OFS_GLOBAL, 1);
        rc(OFS_ERROR, 0);
        @(posedge clk) flt <= 3'h6;
        @(posedge clk) flt <= 3'h0;
        repeat (2) @(posedge clk);
        rc(OFS_ERROR, 32'hBF);
        u_host.wr(OFS_GLOBAL, 2);
        rc(OFS_ERROR, 0);
    endtask
    task automatic t_outputs;
        u_host.wr(8'h20, 8'h14);
        repeat (2) @(posedge clk);
        chk(32'(dout[3:0]), 0);
        u_host.wr(8'h20, 8'h10);
        repeat (2) @(posedge clk);
        chk(32'(dout[2:0]), 7);
        @(posedge clk) lost <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(dout), 0);
        lost <= 1'b0;
        u_host.wr(OFS_GLOBAL, 32'h20);
        rc(OFS_GLOBAL, 32'h20);
        repeat (2) @(posedge clk);
        lost <= 1'b1;
        u_host.wr(8'h20, 8'h14);
        repeat (2) @(posedge clk);
        chk(32'(dout[2:0]), 7);
        lost <= 1'b0;
        rc(8'h1C, 0);
        rc(8'h02, 0);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rc(OFS_GLOBAL, 0);
        rc(OFS_ERROR, 0);
        rc(OFS_IRQ_MASK, 0);
        rc(8'h20, 0);
        t_count_up();
        t_modes();
        t_faults();
        t_outputs();
        finish_test();
    end
endmodule // counter_host_image_interface_bench

// ### dv/hcimg_host.sv
// host controller model driving the register port
`timescale 1ns/1ps
module hcimg_host import hcimg_pkg::*; (
    // clock
    input wire logic clk,
    // register port
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wr_data,
    output logic wr_en,
    output logic rd_en,
    input wire logic [DATA_W-1:0] rd_data
);
    initial begin
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    // host writes acks, set points, one control byte per channel
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        d = rd_data;
    endtask
endmodule // hcimg_host

// ### dv/hcimg_top_assertions.sv
// port checker for the counter host image block
`timescale 1ns/1ps
module hcimg_top_assertions import hcimg_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rd_data,
    // field side
    input wire logic host_link_lost,
    input wire logic [N_CHAN*OUT_PER_CHAN-1:0] dout,
    input wire logic irq
);
    // -------------------------------------------------------
    // shadow of written registers
    // -------------------------------------------------------
    logic ret;
    logic rel;
    logic [7:0] ctl0;
    logic [5:0] msk;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ret <= 1'b0;
            rel <= 1'b0;
            ctl0 <= 8'h00;
            msk <= 6'h00;
        end else if (wr_en) begin
            if (addr == OFS_GLOBAL) begin
                ret <= wr_data[GB_RETAIN];
                rel <= wr_data[GB_RELATIVE];
            end
            if (addr == 8'h20) ctl0 <= wr_data[7:0];
            if (addr == OFS_IRQ_MASK) msk <= wr_data[5:0];
        end
    end
    // -------------------------------------------------------
    // properties
    // -------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rd_idle; !rd_en |=> rd_data == 32'h0; endproperty
    property p_unmapped; rd_en && addr == 8'h1C |=> rd_data == 32'h0; endproperty
    property p_global; rd_en && addr == OFS_GLOBAL |=> rd_data == {26'h0, ret, rel, 4'h0}; endproperty
    property p_ctrl; rd_en && addr == 8'h20 |=> rd_data == {24'h0, ctl0}; endproperty
    property p_mask; rd_en && addr == OFS_IRQ_MASK |=> rd_data == {26'h0, msk}; endproperty
    property p_irq_off; msk == 6'h00 |=> !irq; endproperty
    property p_lost; host_link_lost && !ret |=> dout == 20'h0; endproperty
    property p_retain; host_link_lost && ret ##1 host_link_lost && ret |=> $stable(dout); endproperty
    property p_force; ctl0[CB_FORCE_OFF] && !(host_link_lost && ret) |=> dout[3:0] == 4'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_global: assert property (p_global) else $error("global readback wrong");
    a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
    a_mask: assert property (p_mask) else $error("mask readback wrong");
    a_irq_off: assert property (p_irq_off) else $error("masked irq high");
    a_lost: assert property (p_lost) else $error("outputs not zero on lost link");
    a_retain: assert property (p_retain) else $error("outputs not frozen");
    a_force: assert property (p_force) else $error("outputs not forced off");
    c_lost: cover property (host_link_lost && ret);
    c_irq: cover property ($rose(irq));
    c_force: cover property (ctl0[CB_FORCE_OFF]);
endmodule // hcimg_top_assertions
bind hcimg_top hcimg_top_assertions u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .host_link_lost(host_link_lost), .dout(dout), .irq(irq));

// ### logic/hcimg_chan_if.sv
// control and status bundle between top and one counter channel
`timescale 1ns/1ps
interface hcimg_chan_if;
    import hcimg_pkg::*;
    logic load;
    logic restart;
    logic dir;
    logic relative;
    logic tick;
    logic [MODE_W-1:0] mode;
    logic [CNT_W-1:0] final_sp;
    logic [CNT_W-1:0] first_sp;
    logic [CNT_W-1:0] second_sp;
    logic [CNT_W-1:0] count;
    logic term_hit;
    logic first_hit;
    logic second_hit;
    logic timed_pulse;
    logic overflow;
    modport top (output load, restart, dir, relative, tick, mode, final_sp, first_sp, second_sp,
                 input count, term_hit, first_hit, second_hit, timed_pulse, overflow);
    modport chan (input load, restart, dir, relative, tick, mode, final_sp, first_sp, second_sp,
                  output count, term_hit, first_hit, second_hit, timed_pulse, overflow);
endinterface

// ### logic/hcimg_channel.sv
// one counter channel with set point compare and timed pulse
`timescale 1ns/1ps
module hcimg_channel import hcimg_pkg::*; #(
    parameter int PULSE_CYCLES = TIMED_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link to top
    hcimg_chan_if.chan ch
);
    hcimg_chan_state_type state;
    logic [CNT_W-1:0] remain;
    logic [CNT_W-1:0] progress;
    logic [CNT_W-1:0] preset;
    logic [31:0] pulse_cnt;
    logic term_now;
    logic at_limit;

    assign remain = ch.dir ? ch.count : ch.final_sp - ch.count;
    assign progress = ch.dir ? ch.final_sp - ch.count : ch.count;
    assign preset = ch.dir ? ch.final_sp : VALUE_RESET;
    assign term_now = ch.dir ? (ch.count == VALUE_RESET) : (ch.count >= ch.final_sp);
    assign at_limit = ch.dir ? (ch.count == VALUE_RESET) : (ch.count == {CNT_W{1'b1}});

    // -------------------------------------------------------
    // count engine
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CH_IDLE;
            ch.count <= VALUE_RESET;
            ch.overflow <= 1'b0;
        end else begin
            ch.overflow <= 1'b0;
            if (ch.load) begin
                ch.count <= preset;
                state <= CH_RUN;
            end else if (ch.restart) begin
                state <= CH_RUN;
            end else begin
                unique case (state)
                    CH_IDLE: state <= CH_IDLE;
                    CH_RUN: begin
                        if (term_now) begin
                            state <= CH_DONE;
                        end else if (ch.tick && ch.mode != MODE_OFF) begin
                            if (at_limit) begin
                                ch.overflow <= 1'b1;
                            end else if (ch.dir) begin
                                ch.count <= ch.count - 1'b1;
                            end else begin
                                ch.count <= ch.count + 1'b1;
                            end
                        end
                    end
                    CH_DONE: begin
                        if (ch.tick && ch.mode != MODE_OFF && at_limit) begin
                            ch.overflow <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------
    // set point compare
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch.term_hit <= 1'b0;
            ch.first_hit <= 1'b0;
            ch.second_hit <= 1'b0;
        end else begin
            ch.term_hit <= (state != CH_IDLE) && term_now;
            if (ch.relative) begin
                ch.first_hit <= (state != CH_IDLE) && (remain <= ch.first_sp);
                ch.second_hit <= (state != CH_IDLE) && (remain <= ch.second_sp);
            end else begin
                ch.first_hit <= (state != CH_IDLE) && (progress >= ch.first_sp);
                ch.second_hit <= (state != CH_IDLE) && (progress >= ch.second_sp);
            end
        end
    end

    // -------------------------------------------------------
    // timed terminal pulse
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt <= 32'h0000_0000;
            ch.timed_pulse <= 1'b0;
        end else if ((state != CH_IDLE) && term_now && !ch.term_hit) begin
            pulse_cnt <= 32'(PULSE_CYCLES);
            ch.timed_pulse <= 1'b1;
        end else if (pulse_cnt > 32'h0000_0001) begin
            pulse_cnt <= pulse_cnt - 32'h0000_0001;
        end else begin
            pulse_cnt <= 32'h0000_0000;
            ch.timed_pulse <= 1'b0;
        end
    end
endmodule // hcimg_channel

// ### logic/hcimg_pkg.sv
// constants and types for the counter host image block
package hcimg_pkg;
    // -------------------------------------------------------
    // sizes
    // -------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int N_CHAN = 5;
    localparam int CNT_W = 32;
    localparam int MODE_W = 4;
    // -------------------------------------------------------
    // register map, byte addresses
    // -------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_GLOBAL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ERROR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TERM = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SP1 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SP2 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [2:0] GRP_CTRL = 3'h1;
    localparam logic [2:0] GRP_FINAL = 3'h2;
    localparam logic [2:0] GRP_FIRST = 3'h3;
    localparam logic [2:0] GRP_SECOND = 3'h4;
    localparam logic [2:0] GRP_COUNT = 3'h5;
    // -------------------------------------------------------
    // field positions
    // -------------------------------------------------------
    localparam int GB_ACK_SHORT = 0;
    localparam int GB_ACK_UNDERVOLT = 1;
    localparam int GB_RELATIVE = 4;
    localparam int GB_RETAIN = 5;
    localparam int CB_LOAD = 0;
    localparam int CB_RESTART = 1;
    localparam int CB_FORCE_OFF = 2;
    localparam int CB_DIR = 3;
    localparam int CB_MODE_LSB = 4;
    localparam int ER_CLOCK_KIND = 5;
    localparam int ER_SHORT = 6;
    localparam int ER_POWER = 7;
    localparam int IRQ_FAULT = 5;
    localparam int IRQ_W = 6;
    localparam int OUT_PER_CHAN = 4;
    // -------------------------------------------------------
    // reset values and timing
    // -------------------------------------------------------
    localparam logic [7:0] GLOBAL_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [CNT_W-1:0] VALUE_RESET = 32'h0000_0000;
    localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TIMED_PULSE_NS = 400_000_000;
    localparam int TIMED_PULSE_CYCLES = TIMED_PULSE_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_DONE} hcimg_chan_state_type;
endpackage

// ### logic/hcimg_top.sv
// five channel counter block with host process image registers
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// -----------------------------------------------------------
// -----------------------------------------------------------
module hcimg_top import hcimg_pkg::*; #(
    parameter int PULSE_CYCLES = TIMED_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rd_data,
    // field side
    input wire logic [N_CHAN-1:0] count_in,
    input wire logic short_fault,
    input wire logic undervolt_fault,
    input wire logic clock_fault,
    input wire logic host_link_lost,
    output logic [N_CHAN*OUT_PER_CHAN-1:0] dout,
    // interrupt
    output logic irq
);
    logic relative_mode;
    logic retain_outputs_on_failure;
    logic [7:0] ctrl [N_CHAN];
    logic [CNT_W-1:0] final_val [N_CHAN];
    logic [CNT_W-1:0] first_val [N_CHAN];
    logic [CNT_W-1:0] second_val [N_CHAN];
    logic [N_CHAN-1:0] load_and_begin;
    logic [N_CHAN-1:0] count_restart;
    logic [N_CHAN-1:0] count_prev;
    logic [N_CHAN-1:0] channel_fault_flag;
    logic [N_CHAN-1:0] terminal_setpoint_reached;
    logic [N_CHAN-1:0] first_setpoint_reached;
    logic [N_CHAN-1:0] second_setpoint_reached;
    logic [N_CHAN-1:0] term_prev;
    logic [N_CHAN-1:0] overflow_evt;
    logic [CNT_W-1:0] count_val [N_CHAN];
    logic [N_CHAN*OUT_PER_CHAN-1:0] live_out;
    logic short_flag;
    logic undervolt_flag;
    logic clock_kind;
    logic short_prev;
    logic undervolt_prev;
    logic clock_prev;
    logic short_ack;
    logic undervolt_error_ack;
    logic short_rise;
    logic undervolt_rise;
    logic clock_rise;
    logic failure;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic [7:0] error_byte;
    logic global_wr;
    logic irq_status_wr;
    logic [2:0] grp;
    logic [2:0] idx;
    logic idx_ok;
    logic [DATA_W-1:0] next_rd_data;

    assign grp = addr[7:5];
    assign idx = addr[4:2];
    assign idx_ok = (idx < 3'(N_CHAN)) && (addr[1:0] == 2'h0);
    assign global_wr = wr_en && (addr == OFS_GLOBAL);
    assign irq_status_wr = wr_en && (addr == OFS_IRQ_STATUS);
    assign short_ack = global_wr && wr_data[GB_ACK_SHORT];
    assign undervolt_error_ack = global_wr && wr_data[GB_ACK_UNDERVOLT];
    assign short_rise = short_fault && !short_prev;
    assign undervolt_rise = undervolt_fault && !undervolt_prev;
    assign clock_rise = clock_fault && !clock_prev;
    assign failure = host_link_lost || undervolt_fault;
    assign error_byte = {undervolt_flag, short_flag, clock_kind, channel_fault_flag};

    // -------------------------------------------------------
    // global options
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relative_mode <= GLOBAL_RESET[GB_RELATIVE];
            retain_outputs_on_failure <= GLOBAL_RESET[GB_RETAIN];
        end else if (global_wr) begin
            relative_mode <= wr_data[GB_RELATIVE];
            retain_outputs_on_failure <= wr_data[GB_RETAIN];
        end
    end

    // -------------------------------------------------------
    // per channel registers, commands and channel instances
    // -------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N_CHAN; gi++) begin : g_chan
            hcimg_chan_if cif ();
            logic ctrl_wr;
            assign ctrl_wr = wr_en && idx_ok && (grp == GRP_CTRL) && (idx == 3'(gi));

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl[gi] <= CTRL_RESET;
                    load_and_begin[gi] <= 1'b0;
                    count_restart[gi] <= 1'b0;
                end else begin
                    load_and_begin[gi] <= ctrl_wr && wr_data[CB_LOAD];
                    count_restart[gi] <= ctrl_wr && wr_data[CB_RESTART];
                    if (ctrl_wr) begin
                        ctrl[gi] <= wr_data[7:0];
                    end
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    final_val[gi] <= VALUE_RESET;
                    first_val[gi] <= VALUE_RESET;
                    second_val[gi] <= VALUE_RESET;
                end else if (wr_en && idx_ok && idx == 3'(gi)) begin
                    if (grp == GRP_FINAL) begin
                        final_val[gi] <= wr_data;
                    end
                    if (grp == GRP_FIRST) begin
                        first_val[gi] <= wr_data;
                    end
                    if (grp == GRP_SECOND) begin
                        second_val[gi] <= wr_data;
                    end
                end
            end

            assign cif.load = load_and_begin[gi];
            assign cif.restart = count_restart[gi];
            assign cif.dir = ctrl[gi][CB_DIR];
            assign cif.mode = ctrl[gi][CB_MODE_LSB +: MODE_W];
            assign cif.relative = relative_mode;
            assign cif.tick = count_in[gi] && !count_prev[gi];
            assign cif.final_sp = final_val[gi];
            assign cif.first_sp = first_val[gi];
            assign cif.second_sp = second_val[gi];
            assign count_val[gi] = cif.count;
            assign terminal_setpoint_reached[gi] = cif.term_hit;
            assign first_setpoint_reached[gi] = cif.first_hit;
            assign second_setpoint_reached[gi] = cif.second_hit;
            assign overflow_evt[gi] = cif.overflow;
            // one output group per channel, never shared
            assign live_out[gi*OUT_PER_CHAN +: OUT_PER_CHAN] = ctrl[gi][CB_FORCE_OFF] ? '0 :
                {cif.timed_pulse, cif.term_hit, cif.second_hit, cif.first_hit};

            hcimg_channel #(
                .PULSE_CYCLES(PULSE_CYCLES)
            ) u_chan (
                .clk(clk),
                .rst_n(rst_n),
                .ch(cif.chan)
            );
        end
    endgenerate

    // -------------------------------------------------------
    // edge history
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_prev <= '0;
            term_prev <= '0;
            short_prev <= 1'b0;
            undervolt_prev <= 1'b0;
            clock_prev <= 1'b0;
        end else begin
            count_prev <= count_in;
            term_prev <= terminal_setpoint_reached;
            short_prev <= short_fault;
            undervolt_prev <= undervolt_fault;
            clock_prev <= clock_fault;
        end
    end

    // -------------------------------------------------------
    // fault flags, set wins over acknowledge
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            short_flag <= 1'b0;
        end else if (short_rise) begin
            short_flag <= 1'b1;
        end else if (short_ack) begin
            short_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            undervolt_flag <= 1'b0;
        end else if (undervolt_rise) begin
            undervolt_flag <= 1'b1;
        end else if (undervolt_error_ack) begin
            undervolt_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_fault_flag <= '0;
            clock_kind <= 1'b0;
        end else begin
            if (clock_rise) begin
                channel_fault_flag <= '1;
                clock_kind <= 1'b1;
            end else if (|overflow_evt) begin
                channel_fault_flag <= channel_fault_flag | overflow_evt;
                clock_kind <= 1'b0;
            end else if (undervolt_error_ack) begin
                channel_fault_flag <= '0;
                clock_kind <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------
    // interrupt status and mask
    // -------------------------------------------------------
    assign irq_set = {short_rise || undervolt_rise || clock_rise || (|overflow_evt),
                      terminal_setpoint_reached & ~term_prev};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
        end else if (irq_status_wr) begin
            irq_status <= (irq_status & ~wr_data[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= '0;
        end else if (wr_en && addr == OFS_IRQ_MASK) begin
            irq_mask <= wr_data[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // -------------------------------------------------------
    // discrete outputs with failure handling
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else if (!failure) begin
            dout <= live_out;
        end else if (!retain_outputs_on_failure) begin
            dout <= '0;
        end else begin
            dout <= dout;
        end
    end

    // -------------------------------------------------------
    // read path
    // -------------------------------------------------------
    always_comb begin
        next_rd_data = '0;
        if (addr == OFS_GLOBAL) begin
            next_rd_data[GB_RELATIVE] = relative_mode;
            next_rd_data[GB_RETAIN] = retain_outputs_on_failure;
        end else if (addr == OFS_ERROR) begin
            next_rd_data[7:0] = error_byte;
        end else if (addr == OFS_TERM) begin
            next_rd_data[N_CHAN-1:0] = terminal_setpoint_reached;
        end else if (addr == OFS_SP1) begin
            next_rd_data[N_CHAN-1:0] = first_setpoint_reached;
        end else if (addr == OFS_SP2) begin
            next_rd_data[N_CHAN-1:0] = second_setpoint_reached;
        end else if (addr == OFS_IRQ_STATUS) begin
            next_rd_data[IRQ_W-1:0] = irq_status;
        end else if (addr == OFS_IRQ_MASK) begin
            next_rd_data[IRQ_W-1:0] = irq_mask;
        end else if (idx_ok) begin
            unique case (grp)
                GRP_CTRL: next_rd_data[7:0] = ctrl[idx];
                GRP_FINAL: next_rd_data = final_val[idx];
                GRP_FIRST: next_rd_data = first_val[idx];
                GRP_SECOND: next_rd_data = second_val[idx];
                GRP_COUNT: next_rd_data = count_val[idx];
                default: next_rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= '0;
        end
    end
endmodule // hcimg_top
